// ===== gpc_ports.sv
// general purpose i/o ports: five-bit, fourteen-bit and sixteen-bit
// assumes an axi4-lite master on mclk_i and pad cells outside that
// resolve each pin from level and active-low enable
//
// Overview of operation
// - general output pin drives its stored data bit
// - general output: read returns stored data, not pin
// - general input: read returns live pin level
// - write to an input pin updates storage only
// - direction 0 reads pins, 1 reads data; drive needs 1 and general
// - data registers clear on power-on reset and hardware standby
// - data held through software standby and sleep
// - five-bit port keeps bits 4:0; bits 15:5 read zero
// - fourteen-bit port data bits 15:14 read zero; the pin-state register returns pins 15:14
// - fourteen-bit port bits 13:0 map onto its pins
// - fourteen-bit pin-state register is read-only live pin levels
// - sixteen-bit port bits 15:0 map onto its pins
// - output-disable low floats sixteen-bit general outputs
// - output-disable high lets sixteen-bit outputs drive data
// - every register access completes in four cycles, 8 or 16 bit
// - each data register holds stored output data for its port's implemented bits only
`timescale 1ns/1ps
module gpc_ports (
    // clock and reset
    input  wire logic                          mclk_i,
    input  wire logic                          rstn_i,
    // axi4-lite write address
    input  wire logic [31:0]                   s_axi_awaddr_i,
    input  wire logic                          s_axi_awvalid_i,
    output logic                               s_axi_awready_o,
    // axi4-lite write data
    input  wire logic [31:0]                   s_axi_wdata_i,
    input  wire logic [3:0]                    s_axi_wstrb_i,
    input  wire logic                          s_axi_wvalid_i,
    output logic                               s_axi_wready_o,
    // axi4-lite write response
    output logic [1:0]                         s_axi_bresp_o,
    output logic                               s_axi_bvalid_o,
    input  wire logic                          s_axi_bready_i,
    // axi4-lite read address
    input  wire logic [31:0]                   s_axi_araddr_i,
    input  wire logic                          s_axi_arvalid_i,
    output logic                               s_axi_arready_o,
    // axi4-lite read data
    output logic [31:0]                        s_axi_rdata_o,
    output logic [1:0]                         s_axi_rresp_o,
    output logic                               s_axi_rvalid_o,
    input  wire logic                          s_axi_rready_i,
    // pins: index 0 five-bit, 1 fourteen-bit, 2 sixteen-bit port
    input  wire logic [2:0][15:0]              pad_in_i,
    output gpc_pkg::gpc_pad_t [2:0]            pad_o,
    // device control pins
    input  wire logic                          output_disable_input_n_i,
    input  wire logic                          hw_standby_i
);

    localparam logic [2:0][15:0] PORT_MASK = {gpc_pkg::MASK_E,
                                              gpc_pkg::MASK_D,
                                              gpc_pkg::MASK_C};

    // stored registers
    logic [2:0][15:0]     port_data;
    logic [2:0][15:0]     port_dir;
    logic [2:0][15:0]     port_func;

    // pin input synchronisers
    logic [2:0][15:0]     pin_s1;
    logic [2:0][15:0]     pin_s2;
    logic [2:0][15:0]     pin_s3;
    logic [2:0][15:0]     pin_level;
    logic [2:0]           ctl_s1;
    logic [2:0]           ctl_s2;
    logic [2:0]           ctl_s3;
    logic                 odis_n;
    logic                 standby;

    // write channel state
    logic [31:0]          wr_addr;
    logic [31:0]          wr_data;
    logic [3:0]           wr_strb;
    logic [2:0]           wr_cnt;
    logic                 wr_busy;
    logic                 wr_commit;
    gpc_pkg::gpc_target_t wr_tgt;

    // read channel state
    logic [31:0]          rd_addr;
    logic [2:0]           rd_cnt;
    logic                 rd_busy;
    logic                 rd_done;
    gpc_pkg::gpc_target_t rd_tgt;
    logic [15:0]          rd_word;

    // pad drive
    logic [2:0][15:0]     next_level;
    logic [2:0][15:0]     next_oen;

    // address key to register target
    function automatic gpc_pkg::gpc_target_t decode(input logic [9:0] key);
        gpc_pkg::gpc_target_t t;
        t.sel  = gpc_pkg::GPC_SEL_NONE;
        t.port = 2'h0;
        unique case (key)
            gpc_pkg::KEY_C_DATA: begin
                t = '{gpc_pkg::GPC_SEL_DATA, 2'h0};
            end
            gpc_pkg::KEY_D_DATA: begin
                t = '{gpc_pkg::GPC_SEL_DATA, 2'h1};
            end
            gpc_pkg::KEY_E_DATA: begin
                t = '{gpc_pkg::GPC_SEL_DATA, 2'h2};
            end
            gpc_pkg::KEY_D_PINS: begin
                t = '{gpc_pkg::GPC_SEL_PINS, 2'h1};
            end
            gpc_pkg::KEY_C_DIR: begin
                t = '{gpc_pkg::GPC_SEL_DIR, 2'h0};
            end
            gpc_pkg::KEY_D_DIR: begin
                t = '{gpc_pkg::GPC_SEL_DIR, 2'h1};
            end
            gpc_pkg::KEY_E_DIR: begin
                t = '{gpc_pkg::GPC_SEL_DIR, 2'h2};
            end
            gpc_pkg::KEY_C_FUNC: begin
                t = '{gpc_pkg::GPC_SEL_FUNC, 2'h0};
            end
            gpc_pkg::KEY_D_FUNC: begin
                t = '{gpc_pkg::GPC_SEL_FUNC, 2'h1};
            end
            gpc_pkg::KEY_E_FUNC: begin
                t = '{gpc_pkg::GPC_SEL_FUNC, 2'h2};
            end
            default: begin
                t.sel = gpc_pkg::GPC_SEL_NONE;
            end
        endcase
        return t;
    endfunction

    // byte-lane merge of a 16-bit register
    function automatic logic [15:0] merge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [1:0]  be,
                                          input logic [15:0] mask);
        logic [15:0] r;
        r = old;
        if (be[0]) begin
            r[7:0] = wd[7:0];
        end
        if (be[1]) begin
            r[15:8] = wd[15:8];
        end
        return r & mask;
    endfunction

    // pins and control inputs: three flops, accept when 2nd and 3rd agree
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1    <= '0;
            pin_s2    <= '0;
            pin_s3    <= '0;
            pin_level <= '0;
        end else begin
            pin_s1    <= pad_in_i;
            pin_s2    <= pin_s1;
            pin_s3    <= pin_s2;
            pin_level <= (pin_s3 & ~(pin_s2 ^ pin_s3)) |
                         (pin_level & (pin_s2 ^ pin_s3));
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctl_s1  <= 3'h0;
            ctl_s2  <= 3'h0;
            ctl_s3  <= 3'h0;
            odis_n  <= 1'b0;
            standby <= 1'b0;
        end else begin
            ctl_s1  <= {1'b0, hw_standby_i, output_disable_input_n_i};
            ctl_s2  <= ctl_s1;
            ctl_s3  <= ctl_s2;
            if (ctl_s2[0] == ctl_s3[0]) begin
                odis_n <= ctl_s3[0];
            end
            if (ctl_s2[1] == ctl_s3[1]) begin
                standby <= ctl_s3[1];
            end
        end
    end

    // write address and data taken in either order, then one access
    assign wr_busy   = !s_axi_awready_o && !s_axi_wready_o && !s_axi_bvalid_o;
    assign wr_commit = wr_busy && (wr_cnt == gpc_pkg::ACCESS_LAST);
    assign wr_tgt    = decode(wr_addr[11:2]);

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_awready_o <= 1'b1;
            wr_addr         <= 32'h0;
        end else if (s_axi_awvalid_i && s_axi_awready_o) begin
            s_axi_awready_o <= 1'b0;
            wr_addr         <= s_axi_awaddr_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_awready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_wready_o <= 1'b1;
            wr_data        <= 32'h0;
            wr_strb        <= 4'h0;
        end else if (s_axi_wvalid_i && s_axi_wready_o) begin
            s_axi_wready_o <= 1'b0;
            wr_data        <= s_axi_wdata_i;
            wr_strb        <= s_axi_wstrb_i;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_wready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wr_cnt         <= 3'h0;
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o  <= gpc_pkg::RESP_OKAY;
        end else if (wr_commit) begin
            wr_cnt         <= 3'h0;
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o  <= (wr_tgt.sel == gpc_pkg::GPC_SEL_NONE) ?
                              gpc_pkg::RESP_SLVERR : gpc_pkg::RESP_OKAY;
        end else if (wr_busy) begin
            wr_cnt <= wr_cnt + 3'h1;
        end else if (s_axi_bvalid_o && s_axi_bready_i) begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    // data registers: stored whatever the direction
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_data <= {3{gpc_pkg::RESET_DATA}};
        end else if (standby) begin
            port_data <= {3{gpc_pkg::RESET_DATA}};
        end else begin
            // no other mode input: contents persist otherwise
            for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                if (wr_commit && wr_tgt.sel == gpc_pkg::GPC_SEL_DATA &&
                    wr_tgt.port == 2'(p)) begin
                    // unimplemented bits stay zero
                    port_data[p] <= merge(port_data[p], wr_data[15:0],
                                          wr_strb[1:0], PORT_MASK[p]);
                end
            end
        end
    end

    // direction and pin-function select registers
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_dir  <= {3{gpc_pkg::RESET_DIR}};
            port_func <= {3{gpc_pkg::RESET_FUNC}};
        end else begin
            for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                if (wr_commit && wr_tgt.port == 2'(p)) begin
                    if (wr_tgt.sel == gpc_pkg::GPC_SEL_DIR) begin
                        port_dir[p] <= merge(port_dir[p], wr_data[15:0],
                                             wr_strb[1:0], PORT_MASK[p]);
                    end
                    if (wr_tgt.sel == gpc_pkg::GPC_SEL_FUNC) begin
                        port_func[p] <= merge(port_func[p], wr_data[15:0],
                                              wr_strb[1:0], PORT_MASK[p]);
                    end
                end
            end
        end
    end

    // read channel: address taken, answered after the access time
    assign rd_busy = !s_axi_arready_o && !s_axi_rvalid_o;
    assign rd_done = rd_busy && (rd_cnt == gpc_pkg::ACCESS_LAST);
    assign rd_tgt  = decode(rd_addr[11:2]);

    always_comb begin
        rd_word = 16'h0000;
        unique case (rd_tgt.sel)
            gpc_pkg::GPC_SEL_DATA: begin
                // per bit: direction 1 reads storage, 0 reads pin
                // masked bits read zero
                rd_word = ((port_data[rd_tgt.port] & port_dir[rd_tgt.port]) |
                           (pin_level[rd_tgt.port] & ~port_dir[rd_tgt.port]))
                          & PORT_MASK[rd_tgt.port];
            end
            gpc_pkg::GPC_SEL_PINS: begin
                // live pins only; writes to it are ignored
                rd_word = pin_level[gpc_pkg::PORT_D];
            end
            gpc_pkg::GPC_SEL_DIR: begin
                rd_word = port_dir[rd_tgt.port];
            end
            gpc_pkg::GPC_SEL_FUNC: begin
                rd_word = port_func[rd_tgt.port];
            end
            gpc_pkg::GPC_SEL_NONE: begin
                rd_word = 16'h0000;
            end
        endcase
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s_axi_arready_o <= 1'b1;
            rd_addr         <= 32'h0;
        end else if (s_axi_arvalid_i && s_axi_arready_o) begin
            s_axi_arready_o <= 1'b0;
            rd_addr         <= s_axi_araddr_i;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_arready_o <= 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_cnt         <= 3'h0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o  <= 32'h0;
            s_axi_rresp_o  <= gpc_pkg::RESP_OKAY;
        end else if (rd_done) begin
            rd_cnt         <= 3'h0;
            s_axi_rvalid_o <= 1'b1;
            s_axi_rdata_o  <= {16'h0000, rd_word};
            s_axi_rresp_o  <= (rd_tgt.sel == gpc_pkg::GPC_SEL_NONE) ?
                              gpc_pkg::RESP_SLVERR : gpc_pkg::RESP_OKAY;
        end else if (rd_busy) begin
            rd_cnt <= rd_cnt + 3'h1;
        end else if (s_axi_rvalid_o && s_axi_rready_i) begin
            s_axi_rvalid_o <= 1'b0;
        end
    end

    // pad drive per port
    for (genvar p = 0; p < gpc_pkg::NPORT; p++) begin : g_pad
        logic [15:0] drive;
        logic        allow;
        // output-disable acts on the sixteen-bit port only
        assign allow = (p == gpc_pkg::PORT_E) ? odis_n : 1'b1;
        // general function and direction 1 drive the pin
        assign drive = port_func[p] & port_dir[p] & PORT_MASK[p] &
                       {16{allow}};
        assign next_level[p] = port_data[p] & drive;
        assign next_oen[p]   = ~drive;
    end

    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                pad_o[p].level <= 16'h0000;
                pad_o[p].oen   <= 16'hffff;
            end
        end else begin
            for (int p = 0; p < gpc_pkg::NPORT; p++) begin
                pad_o[p].level <= next_level[p];
                pad_o[p].oen   <= next_oen[p];
            end
        end
    end

endmodule

// ===== gpc_pkg.sv
// package for the three-port general purpose i/o block
// assumes one 40 MHz clock and an axi4-lite master on the register side
package gpc_pkg;

    // ports handled: five-bit, fourteen-bit and sixteen-bit
    localparam int          NPORT         = 3;
    localparam int          PW            = 16;
    localparam int          PORT_C        = 0;
    localparam int          PORT_D        = 1;
    localparam int          PORT_E        = 2;

    // printed register indices; byte address is four times the index
    localparam logic [31:0] IDX_C_DATA    = 32'hfffff73e;
    localparam logic [31:0] IDX_D_DATA    = 32'hfffff746;
    localparam logic [31:0] IDX_E_DATA    = 32'hfffff754;
    localparam logic [31:0] IDX_D_PINS    = 32'hfffff784;
    // direction and pin-function select registers
    localparam logic [31:0] IDX_C_DIR     = 32'hfffff700;
    localparam logic [31:0] IDX_D_DIR     = 32'hfffff701;
    localparam logic [31:0] IDX_E_DIR     = 32'hfffff702;
    localparam logic [31:0] IDX_C_FUNC    = 32'hfffff704;
    localparam logic [31:0] IDX_D_FUNC    = 32'hfffff705;
    localparam logic [31:0] IDX_E_FUNC    = 32'hfffff706;

    // the block decodes the low index bits (byte address bits 11:2)
    localparam int          KEY_W         = 10;
    localparam logic [9:0]  KEY_C_DATA    = IDX_C_DATA[9:0];
    localparam logic [9:0]  KEY_D_DATA    = IDX_D_DATA[9:0];
    localparam logic [9:0]  KEY_E_DATA    = IDX_E_DATA[9:0];
    localparam logic [9:0]  KEY_D_PINS    = IDX_D_PINS[9:0];
    localparam logic [9:0]  KEY_C_DIR     = IDX_C_DIR[9:0];
    localparam logic [9:0]  KEY_D_DIR     = IDX_D_DIR[9:0];
    localparam logic [9:0]  KEY_E_DIR     = IDX_E_DIR[9:0];
    localparam logic [9:0]  KEY_C_FUNC    = IDX_C_FUNC[9:0];
    localparam logic [9:0]  KEY_D_FUNC    = IDX_D_FUNC[9:0];
    localparam logic [9:0]  KEY_E_FUNC    = IDX_E_FUNC[9:0];

    // implemented bits of each port
    localparam logic [15:0] MASK_C        = 16'h001f;
    localparam logic [15:0] MASK_D        = 16'h3fff;
    localparam logic [15:0] MASK_E        = 16'hffff;

    // reset values
    localparam logic [15:0] RESET_DATA    = 16'h0000;
    localparam logic [15:0] RESET_DIR     = 16'h0000;
    localparam logic [15:0] RESET_FUNC    = 16'h0000;

    // register access latency in clock cycles
    localparam logic [2:0]  ACCESS_CYCLES = 3'h4;
    localparam logic [2:0]  ACCESS_LAST   = ACCESS_CYCLES - 3'h1;

    localparam logic [1:0]  RESP_OKAY     = 2'h0;
    localparam logic [1:0]  RESP_SLVERR   = 2'h2;

    // one port's pad drive: level and active-low output enable
    typedef struct packed {
        logic [15:0] level;
        logic [15:0] oen;
    } gpc_pad_t;

    // register the bus has addressed
    typedef enum logic [2:0] {
        GPC_SEL_NONE,
        GPC_SEL_DATA,
        GPC_SEL_PINS,
        GPC_SEL_DIR,
        GPC_SEL_FUNC
    } gpc_sel_t;

    typedef struct packed {
        gpc_sel_t   sel;
        logic [1:0] port;
    } gpc_target_t;

endpackage

// ===== gpc_board.sv
// board model for the port pins of the three-port i/o block
// assumes pad_o from the block and the board's own levels from the bench
`timescale 1ns/1ps
module gpc_board (
    // block side
    input  wire gpc_pkg::gpc_pad_t [2:0] pad_i,
    // bench side
    input  wire logic [2:0][15:0]        board_i,
    output logic [2:0][15:0]             pin_o
);
    always_comb begin
        for (int p = 0; p < 3; p++) begin
            for (int b = 0; b < 16; b++) begin
                // a floated pin shows the board's level, never the last drive
                pin_o[p][b] = pad_i[p].oen[b] ? board_i[p][b]
                    : pad_i[p].level[b];
            end
        end
    end
endmodule

// ===== gpc_ports_chk.sv
// assertions on the register bus and pad outputs of the port block
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/1ps
module gpc_ports_chk (
    // clock and reset
    input wire logic                    mclk_i,
    input wire logic                    rstn_i,
    // register bus
    input wire logic                    s_axi_awvalid_i,
    input wire logic                    s_axi_awready_o,
    input wire logic                    s_axi_wvalid_i,
    input wire logic                    s_axi_wready_o,
    input wire logic [1:0]              s_axi_bresp_o,
    input wire logic                    s_axi_bvalid_o,
    input wire logic                    s_axi_bready_i,
    input wire logic                    s_axi_arvalid_i,
    input wire logic                    s_axi_arready_o,
    input wire logic [31:0]             s_axi_rdata_o,
    input wire logic                    s_axi_rvalid_o,
    input wire logic                    s_axi_rready_i,
    // pins
    input wire gpc_pkg::gpc_pad_t [2:0] pad_o,
    input wire logic                    output_disable_input_n_i
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rstn_i);

    property p_wr_lat;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o
        |=> (!s_axi_bvalid_o) [*4] ##1 s_axi_bvalid_o;
    endproperty
    a_wr_lat: assert property (p_wr_lat)
        else $error("write answer not after four cycles");

    property p_rd_lat;
        s_axi_arvalid_i && s_axi_arready_o
        |=> (!s_axi_rvalid_o) [*4] ##1 s_axi_rvalid_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat)
        else $error("read answer not after four cycles");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i
        |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold)
        else $error("write answer dropped early");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i
        |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold)
        else $error("read answer dropped early");

    property p_busy;
        s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
    endproperty
    a_busy: assert property (p_busy)
        else $error("write accepted while answer pending");
    property p_rd_hi;
        s_axi_rvalid_o
        |-> !s_axi_arready_o && s_axi_rdata_o[31:16] == 16'h0000;
    endproperty
    a_rd_hi: assert property (p_rd_hi)
        else $error("read data above sixteen bits");

    property p_spare;
        pad_o[0].oen[15:5] == 11'h7ff && pad_o[0].level[15:5] == 11'h000
        && pad_o[1].oen[15:14] == 2'h3 && pad_o[1].level[15:14] == 2'h0;
    endproperty
    a_spare: assert property (p_spare)
        else $error("unimplemented pin driven");

    property p_odis;
        (!output_disable_input_n_i) [*8] |-> pad_o[2].oen == 16'hffff;
    endproperty
    a_odis: assert property (p_odis)
        else $error("sixteen-bit port drives while disabled");
endmodule

bind gpc_ports gpc_ports_chk u_chk (
    .mclk_i, .rstn_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i,
    .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
    .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rvalid_o,
    .s_axi_rready_i, .pad_o, .output_disable_input_n_i
);

// ===== tb_top.sv
// self-checking bench for the three-port i/o block
// assumes the board model and checker are compiled before it
`timescale 1ns/1ps
module tb_top;
    localparam logic [11:0] A_CD = {gpc_pkg::KEY_C_DATA, 2'h0};
    localparam logic [11:0] A_DD = {gpc_pkg::KEY_D_DATA, 2'h0};
    localparam logic [11:0] A_ED = {gpc_pkg::KEY_E_DATA, 2'h0};
    localparam logic [11:0] A_DP = {gpc_pkg::KEY_D_PINS, 2'h0};
    localparam logic [11:0] A_CR = {gpc_pkg::KEY_C_DIR, 2'h0};
    localparam logic [11:0] A_DR = {gpc_pkg::KEY_D_DIR, 2'h0};
    localparam logic [11:0] A_ER = {gpc_pkg::KEY_E_DIR, 2'h0};
    localparam logic [11:0] A_CF = {gpc_pkg::KEY_C_FUNC, 2'h0};
    localparam logic [11:0] A_DF = {gpc_pkg::KEY_D_FUNC, 2'h0};
    localparam logic [11:0] A_EF = {gpc_pkg::KEY_E_FUNC, 2'h0};
    localparam logic [1:0]  OK   = gpc_pkg::RESP_OKAY;
    localparam logic [1:0]  ERR  = gpc_pkg::RESP_SLVERR;

    logic             mclk_i = 1'b0, rstn_i = 1'b0, hw_standby_i = 1'b0;
    logic             output_disable_input_n_i = 1'b1;
    logic             s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
    logic             s_axi_arvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic             s_axi_rready_i = 1'b0;
    logic [3:0]       s_axi_wstrb_i = 4'h0;
    logic [31:0]      s_axi_awaddr_i = '0, s_axi_wdata_i = '0;
    logic [31:0]      s_axi_araddr_i = '0, s_axi_rdata_o;
    logic             s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
    logic             s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0]       s_axi_bresp_o, s_axi_rresp_o;
    logic [2:0][15:0] pin, bv = '0;
    gpc_pkg::gpc_pad_t [2:0] pad_o;
    int               fail_count = 0, n_tests = 0;

    gpc_ports DUT (
        .mclk_i, .rstn_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i,
        .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .pad_in_i(pin),
        .pad_o, .output_disable_input_n_i, .hw_standby_i
    );
    gpc_board u_board (.pad_i(pad_o), .board_i(bv), .pin_o(pin));

    initial begin
        forever #12.5 mclk_i = ~mclk_i;
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test;
        $display("compares %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one bus access; the answer's ready is raised after the first cycle, before the answer shows, and held until it is taken
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [15:0] d, input logic [3:0] s,
                       input logic [31:0] ed, input logic [1:0] er);
        int n;
        logic ta, tw, tr, rv;
        logic [31:0] q;
        logic [1:0] r;
        @(posedge mclk_i);
        s_axi_awaddr_i <= {20'h0, a};
        s_axi_araddr_i <= {20'h0, a};
        s_axi_wdata_i <= {16'h0, d};
        s_axi_wstrb_i <= s;
        s_axi_awvalid_i <= w;
        s_axi_wvalid_i <= w;
        s_axi_arvalid_i <= !w;
        n = 0;
        tr = 1'b0;
        while (!tr) begin
            @(negedge mclk_i);
            ta = w ? s_axi_awvalid_i && s_axi_awready_o
                   : s_axi_arvalid_i && s_axi_arready_o;
            tw = s_axi_wvalid_i && s_axi_wready_o;
            rv = w ? s_axi_bvalid_o : s_axi_rvalid_o;
            tr = rv && (w ? s_axi_bready_i : s_axi_rready_i);
            q = w ? 32'h0 : s_axi_rdata_o;
            r = w ? s_axi_bresp_o : s_axi_rresp_o;
            n++;
            if (n > 40) begin
                fail_count++;
                $display("BAD %0t no bus answer", $time);
                finish_test();
            end
            @(posedge mclk_i);
            if (ta && w) s_axi_awvalid_i <= 1'b0;
            if (ta && !w) s_axi_arvalid_i <= 1'b0;
            if (tw) s_axi_wvalid_i <= 1'b0;
            s_axi_bready_i <= w && !tr;
            s_axi_rready_i <= !w && !tr;
        end
        chk(q, ed);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic see(input int c);
        repeat (c) @(posedge mclk_i);
        @(negedge mclk_i);
    endtask

    task automatic t_inputs;
        bus(1'b0, 12'hffc, 16'h0, 4'h0, 32'h0, ERR);
        bus(1'b1, 12'hffc, 16'hffff, 4'h3, 32'h0, ERR);
        @(posedge mclk_i);
        bv <= {16'h9c3e, 16'hc5a3, 16'hffff};
        see(8);
        bus(1'b0, A_CD, 16'h0, 4'h0, 32'h001f, OK);
        bus(1'b0, A_DD, 16'h0, 4'h0, 32'h05a3, OK);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h9c3e, OK);
        bus(1'b1, A_DD, 16'h1234, 4'h3, 32'h0, OK);
        bus(1'b1, A_DP, 16'h0000, 4'h3, 32'h0, OK);
        see(2);
        chk({16'h0, pad_o[1].oen}, 32'hffff);
        bus(1'b0, A_DP, 16'h0, 4'h0, 32'hc5a3, OK);
        bus(1'b0, A_DD, 16'h0, 4'h0, 32'h05a3, OK);
    endtask

    task automatic t_outputs;
        bus(1'b1, A_CF, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_DF, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_EF, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_CR, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_DR, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_ER, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_CD, 16'hffff, 4'h3, 32'h0, OK);
        bus(1'b1, A_ED, 16'ha55a, 4'h3, 32'h0, OK);
        see(2);
        chk({pad_o[1].oen, pad_o[1].level}, 32'hc0001234);
        chk({pad_o[0].oen, pad_o[0].level}, 32'hffe0001f);
        chk({pad_o[2].oen, pad_o[2].level}, 32'h0000a55a);
        bus(1'b0, A_CD, 16'h0, 4'h0, 32'h001f, OK);
        bus(1'b0, A_DD, 16'h0, 4'h0, 32'h1234, OK);
        bus(1'b0, A_CR, 16'h0, 4'h0, 32'h001f, OK);
        bus(1'b1, A_ED, 16'h7700, 4'h2, 32'h0, OK);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h775a, OK);
        bus(1'b1, A_ED, 16'h0011, 4'h1, 32'h0, OK);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h7711, OK);
        bus(1'b1, A_DF, 16'h0000, 4'h3, 32'h0, OK);
        see(2);
        chk({16'h0, pad_o[1].oen}, 32'hffff);
        bus(1'b0, A_DD, 16'h0, 4'h0, 32'h1234, OK);
        bus(1'b1, A_DR, 16'h0000, 4'h3, 32'h0, OK);
        bus(1'b0, A_DD, 16'h0, 4'h0, 32'h05a3, OK);
    endtask

    task automatic t_disable;
        @(posedge mclk_i);
        output_disable_input_n_i <= 1'b0;
        see(10);
        chk({16'h0, pad_o[2].oen}, 32'hffff);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h7711, OK);
        @(posedge mclk_i);
        output_disable_input_n_i <= 1'b1;
        see(10);
        chk({pad_o[2].oen, pad_o[2].level}, 32'h00007711);
    endtask

    task automatic t_standby;
        see(20);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h7711, OK);
        @(posedge mclk_i);
        hw_standby_i <= 1'b1;
        see(8);
        @(posedge mclk_i);
        hw_standby_i <= 1'b0;
        see(8);
        chk({pad_o[2].oen, pad_o[2].level}, 32'h0);
        bus(1'b0, A_ED, 16'h0, 4'h0, 32'h0, OK);
        bus(1'b0, A_CD, 16'h0, 4'h0, 32'h0, OK);
    endtask

    initial begin
        repeat (2) @(posedge mclk_i);
        rstn_i <= 1'b1;
        t_inputs();
        t_outputs();
        t_disable();
        t_standby();
        finish_test();
    end
endmodule
